// ==== design/sci_control_port.sv ====
// software control port: strap decode, 2-wire slave, configuration register
// assumes: pins are asynchronous to clk_i; sclk_i is the serial clock pin
`timescale 1ns/100ps
module sci_control_port (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic software_control_strap_i,
    input wire logic interface_mode_strap_i,
    input wire logic serial_data_io_i,
    output logic serial_data_io_o,
    output logic serial_data_io_oe_o,
    input wire logic data_out_or_address_low_pin_i,
    output logic data_out_or_address_low_pin_o,
    output logic data_out_or_address_low_pin_oe_o,
    input wire logic chip_select_or_address_high_pin_i,
    input wire logic write_only_i,
    input wire logic irq_pending_i,
    output logic alert_o,
    output logic alert_oe_o,
    output logic software_mode_o,
    output logic two_wire_mode_o,
    output logic four_wire_select_o,
    output logic chip_select_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wr_addr_o,
    output logic [15:0] reg_wr_data_o
);
    import sci_pkg::*;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        logic tog_s1;
        logic tog_s2;
        logic tog_s3;
        logic sw_s1;
        logic sw_s2;
        logic im_s1;
        logic im_s2;
        logic a0_s1;
        logic a0_s2;
        logic a1_s1;
        logic a1_s2;
        sci_state_type state;
        sci_phase_type phase;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic rw;
        logic ara;
        logic [7:0] reg_addr;
        logic [7:0] hi_byte;
        logic [7:0] txbyte;
        logic sda_oe;
        logic [15:0] cfg;
        logic wr;
        logic [7:0] wr_addr;
        logic [15:0] wr_data;
    } sci_ctl_type;

    sci_ctl_type q;
    sci_ctl_type n;

    logic link_bit;
    logic link_tog;
    logic [15:0] mem_rdata;
    logic rise;
    logic fall;
    logic start_ev;
    logic stop_ev;
    logic two_wire;
    logic auto_inc;
    logic [7:0] dev_byte;
    logic [15:0] word;
    logic [7:0] nb;

    function automatic logic is_cfg(input logic [7:0] addr);
        return addr == CFG_ADDR;
    endfunction : is_cfg

    function automatic logic [15:0] rd_word(input logic [7:0] addr,
                                            input logic [15:0] cfg,
                                            input logic [15:0] mem);
        return is_cfg(addr) ? cfg : mem;
    endfunction : rd_word

    // ************************************************************
    // serial clock domain and register storage
    // ************************************************************
    sci_link_capture u_link (
        .sclk_i(sclk_i),
        .rst_n_i(rst_n_i),
        .sda_i(serial_data_io_i),
        .bit_o(link_bit),
        .tog_o(link_tog)
    );

    sci_reg_mem u_mem (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(q.wr & ~is_cfg(q.wr_addr)),
        .waddr_i(q.wr_addr),
        .wdata_i(q.wr_data),
        .raddr_i(q.reg_addr),
        .rdata_o(mem_rdata)
    );

    // ************************************************************
    // bus events and decode
    // ************************************************************
    assign rise = q.tog_s3 ^ q.tog_s2;
    assign fall = q.scl_s3 & ~q.scl_s2;
    assign start_ev = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
    assign stop_ev = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
    assign two_wire = q.sw_s2 & ~q.im_s2;
    assign auto_inc = q.cfg[AUTO_INC_BIT];
    assign dev_byte = DEV_BASE | {5'h00, q.a1_s2, q.a0_s2, 1'b0};
    assign word = rd_word(q.reg_addr, q.cfg, mem_rdata);

    // ************************************************************
    // protocol engine
    // ************************************************************
    always_comb begin
        n = q;
        nb = 8'h00;
        n.scl_s1 = sclk_i;
        n.scl_s2 = q.scl_s1;
        n.scl_s3 = q.scl_s2;
        n.sda_s1 = serial_data_io_i;
        n.sda_s2 = q.sda_s1;
        n.sda_s3 = q.sda_s2;
        n.tog_s1 = link_tog;
        n.tog_s2 = q.tog_s1;
        n.tog_s3 = q.tog_s2;
        n.sw_s1 = software_control_strap_i;
        n.sw_s2 = q.sw_s1;
        n.im_s1 = interface_mode_strap_i;
        n.im_s2 = q.im_s1;
        n.a0_s1 = data_out_or_address_low_pin_i;
        n.a0_s2 = q.a0_s1;
        n.a1_s1 = chip_select_or_address_high_pin_i;
        n.a1_s2 = q.a1_s1;
        n.wr = 1'b0;
        if (q.wr && is_cfg(q.wr_addr)) begin
            n.cfg = q.wr_data;
        end
        if (!two_wire) begin
            n.state = ST_IDLE;
            n.sda_oe = 1'b0;
        end else if (stop_ev) begin
            n.state = ST_IDLE;
            n.sda_oe = 1'b0;
        end else if (start_ev) begin
            n.state = ST_DEV;
            n.bitcnt = 4'h0;
            n.sda_oe = 1'b0;
        end else begin
            unique case (q.state)
                ST_IDLE: begin
                    n.sda_oe = 1'b0;
                end
                ST_DEV: begin
                    if (rise && q.bitcnt != BYTE_BITS) begin
                        n.shreg = {q.shreg[6:0], link_bit};
                        n.bitcnt = q.bitcnt + 4'h1;
                    end else if (fall && q.bitcnt == BYTE_BITS) begin
                        if (q.shreg == ARA_READ && q.cfg[ALERT_EN_BIT]
                                && irq_pending_i) begin
                            n.ara = 1'b1;
                            n.rw = 1'b1;
                            n.sda_oe = 1'b1;
                            n.state = ST_DEV_ACK;
                        end else if (q.shreg[7:1] == dev_byte[7:1]
                                && !(q.shreg[0] && write_only_i)) begin
                            n.ara = 1'b0;
                            n.rw = q.shreg[0];
                            n.sda_oe = 1'b1;
                            n.state = ST_DEV_ACK;
                        end else begin
                            n.state = ST_IDLE;
                        end
                    end
                end
                ST_DEV_ACK: begin
                    if (fall) begin
                        n.bitcnt = 4'h0;
                        if (q.rw) begin
                            nb = q.ara ? dev_byte : word[15:8];
                            n.txbyte = nb;
                            n.sda_oe = ~nb[7];
                            n.phase = PH_HI;
                            n.state = ST_TX;
                        end else begin
                            n.sda_oe = 1'b0;
                            n.phase = PH_REG;
                            n.state = ST_RX;
                        end
                    end
                end
                ST_RX: begin
                    if (rise && q.bitcnt != BYTE_BITS) begin
                        n.shreg = {q.shreg[6:0], link_bit};
                        n.bitcnt = q.bitcnt + 4'h1;
                    end else if (fall && q.bitcnt == BYTE_BITS) begin
                        n.sda_oe = 1'b1;
                        n.state = ST_RX_ACK;
                        unique case (q.phase)
                            PH_REG: begin
                                n.reg_addr = q.shreg;
                                n.phase = PH_HI;
                            end
                            PH_HI: begin
                                n.hi_byte = q.shreg;
                                n.phase = PH_LO;
                            end
                            PH_LO: begin
                                n.wr = 1'b1;
                                n.wr_addr = q.reg_addr;
                                n.wr_data = {q.hi_byte, q.shreg};
                                if (auto_inc) begin
                                    n.reg_addr = q.reg_addr + 8'h01;
                                    n.phase = PH_HI;
                                end else begin
                                    n.phase = PH_DONE;
                                end
                            end
                            PH_DONE: begin
                                n.sda_oe = 1'b0;
                                n.state = ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_RX_ACK: begin
                    if (fall) begin
                        n.sda_oe = 1'b0;
                        n.bitcnt = 4'h0;
                        n.state = ST_RX;
                    end
                end
                ST_TX: begin
                    if (fall) begin
                        if (q.bitcnt == LAST_TX_BIT) begin
                            n.sda_oe = 1'b0;
                            n.state = ST_TX_ACK;
                        end else begin
                            n.txbyte = {q.txbyte[6:0], 1'b0};
                            n.sda_oe = ~q.txbyte[6];
                            n.bitcnt = q.bitcnt + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (rise) begin
                        if (q.phase == PH_LO && !q.ara && auto_inc) begin
                            n.reg_addr = q.reg_addr + 8'h01;
                        end
                        n.phase = (q.phase == PH_HI) ? PH_LO : PH_HI;
                        if (link_bit || q.ara) begin
                            n.state = ST_IDLE;
                        end else begin
                            n.state = ST_TX_WAIT;
                        end
                    end
                end
                ST_TX_WAIT: begin
                    if (fall) begin
                        nb = (q.phase == PH_HI) ? word[15:8] : word[7:0];
                        n.txbyte = nb;
                        n.sda_oe = ~nb[7];
                        n.bitcnt = 4'h0;
                        n.state = ST_TX;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
            q.sda_s3 <= 1'b1;
            q.cfg <= CFG_RST;
        end else begin
            q <= n;
        end
    end

    // ************************************************************
    // pin and mode outputs
    // ************************************************************
    assign serial_data_io_o = 1'b0;
    assign serial_data_io_oe_o = q.sda_oe;
    assign software_mode_o = q.sw_s2;
    assign two_wire_mode_o = two_wire;
    assign four_wire_select_o = q.sw_s2 & q.im_s2 & q.cfg[FOUR_WIRE_BIT];
    assign data_out_or_address_low_pin_o = 1'b0;
    assign data_out_or_address_low_pin_oe_o = four_wire_select_o
        & ~q.cfg[OPEN_DRAIN_BIT];
    assign chip_select_o = q.sw_s2 & q.im_s2 & ~q.a1_s2;
    assign alert_o = 1'b0;
    assign alert_oe_o = q.cfg[ALERT_EN_BIT] & irq_pending_i;
    assign reg_wr_o = q.wr;
    assign reg_wr_addr_o = q.wr_addr;
    assign reg_wr_data_o = q.wr_data;

    // ************************************************************
    // checks
    // ************************************************************
    oe_scl_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(q.sda_oe) |-> !q.scl_s2)
        else $error("data line pulled while clock high");
    mode_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !two_wire |=> q.state == ST_IDLE && !q.sda_oe)
        else $error("engine active outside 2-wire mode");
    cfg_reset_a: assert property (@(posedge clk_i)
        $rose(rst_n_i) |-> q.cfg == CFG_RST)
        else $error("config register reset value wrong");
    addr_ack_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (two_wire && !stop_ev && !start_ev && q.state == ST_DEV && fall
         && q.bitcnt == BYTE_BITS && q.shreg[7:1] == dev_byte[7:1]
         && !(q.shreg[0] && write_only_i)) |=> q.sda_oe ##0
        q.state == ST_DEV_ACK)
        else $error("matching address not acknowledged");
    addr_miss_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (two_wire && !stop_ev && !start_ev && q.state == ST_DEV && fall
         && q.bitcnt == BYTE_BITS && q.shreg[7:1] != dev_byte[7:1]
         && q.shreg != ARA_READ) |=> q.state == ST_IDLE && !q.sda_oe)
        else $error("foreign address not ignored");
    stop_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (two_wire && stop_ev) |=> q.state == ST_IDLE [*2])
        else $error("stop did not end the transfer");
    start_dev_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (two_wire && start_ev && !stop_ev) |=> q.state == ST_DEV
        && q.bitcnt == 4'h0)
        else $error("start did not open address phase");
    word_inc_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(q.wr) && auto_inc |-> q.reg_addr == q.wr_addr + 8'h01)
        else $error("register address not advanced after word");
    drive_type_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q.sw_s2 && q.im_s2 && q.cfg[FOUR_WIRE_BIT])
        |-> data_out_or_address_low_pin_oe_o != q.cfg[OPEN_DRAIN_BIT])
        else $error("data out drive type wrong");
    alert_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q.ara && q.state == ST_TX && irq_pending_i) |-> alert_oe_o)
        else $error("alert dropped during alert response");

endmodule : sci_control_port

// ==== design/sci_link_capture.sv ====
// serial clock domain: samples the data line on each rising clock edge
// assumes: sclk_i toggles at least three times while rst_n_i is low
`timescale 1ns/100ps
module sci_link_capture (
    input wire logic sclk_i,
    input wire logic rst_n_i,
    input wire logic sda_i,
    output logic bit_o,
    output logic tog_o
);
    import sci_pkg::*;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic bit_v;
        logic tog;
    } sci_link_type;

    sci_link_type q;
    sci_link_type n;

    // ************************************************************
    // capture; toggle marks a new bit for the system clock side
    // ************************************************************
    always_comb begin
        n = q;
        n.rst_s1 = rst_n_i;
        n.rst_s2 = q.rst_s1;
        if (!q.rst_s2) begin
            n.bit_v = 1'b1;
            n.tog = 1'b0;
        end else begin
            n.bit_v = sda_i;
            n.tog = ~q.tog;
        end
    end

    always_ff @(posedge sclk_i) begin
        q <= n;
    end

    assign bit_o = q.bit_v;
    assign tog_o = q.tog;

endmodule : sci_link_capture

// ==== design/sci_pkg.sv ====
// constants and types of the software control port
// assumes: included before every other design file
package sci_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] CFG_ADDR = 8'h28;
    localparam logic [15:0] CFG_RST = 16'h0002;
    localparam int OPEN_DRAIN_BIT = 5;
    localparam int FOUR_WIRE_BIT = 4;
    localparam int ALERT_EN_BIT = 3;
    localparam int AUTO_INC_BIT = 1;

    // ************************************************************
    // bus addressing
    // ************************************************************
    localparam logic [7:0] DEV_BASE = 8'hD8;
    localparam logic [7:0] ARA_READ = 8'h19;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_DEV_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_TX_WAIT
    } sci_state_type;

    typedef enum logic [1:0] {
        PH_REG,
        PH_HI,
        PH_LO,
        PH_DONE
    } sci_phase_type;

endpackage : sci_pkg

// ==== design/sci_reg_mem.sv ====
// register storage: 256 words of 16 bits, one write and one read port
// assumes: clk_i domain, synchronous active-low reset on read data only
`timescale 1ns/100ps
module sci_reg_mem (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic we_i,
    input wire logic [7:0] waddr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [7:0] raddr_i,
    output logic [15:0] rdata_o
);
    import sci_pkg::*;

    logic [15:0] mem_ff [0:255];
    logic [15:0] rdata_ff;

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_ff[waddr_i] <= wdata_i;
        end
    end

    // registered read, one cycle after the address
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= mem_ff[raddr_i];
        end
    end

    assign rdata_o = rdata_ff;

endmodule : sci_reg_mem

// ==== verification/sci_host_model.sv ====
// host side model: 2-wire bus master on the serial clock and data line
// assumes: tick_i is the link clock, sda_i the resolved line with pull-up
`timescale 1ns/100ps
module sci_host_model (
    input wire logic tick_i,
    input wire logic sda_i,
    output logic sclk_o,
    output logic sda_low_o
);
    // clock stands high, line released, outside frames
    initial begin
        sclk_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // ************************************************************
    // bus conditions
    // ************************************************************
    // clock pulses with the line held high, for link domain reset
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge tick_i) sclk_o <= 1'b0;
            @(posedge tick_i) sclk_o <= 1'b1;
        end
    endtask : pulses

    // start, or repeated start when the clock is low
    // clock level read after an edge, once the last update has landed
    task automatic start();
        @(posedge tick_i) sda_low_o <= 1'b0;
        if (sclk_o === 1'b0) begin
            @(posedge tick_i) sclk_o <= 1'b1;
        end
        @(posedge tick_i) sda_low_o <= 1'b1;
        @(posedge tick_i) sclk_o <= 1'b0;
    endtask : start

    task automatic stop();
        @(posedge tick_i) sda_low_o <= 1'b1;
        @(posedge tick_i) sclk_o <= 1'b1;
        @(posedge tick_i) sda_low_o <= 1'b0;
    endtask : stop

    // eight bits msb first plus the acknowledge slot; 1 releases the line
    task automatic xfer(input logic [7:0] tx, input logic last,
                        output logic [7:0] rx, output logic ack_n);
        logic [8:0] sh;
        sh = {tx, last};
        for (int i = 8; i >= 0; i--) begin
            @(posedge tick_i) sda_low_o <= !sh[i];
            @(posedge tick_i) sclk_o <= 1'b1;
            @(posedge tick_i) begin
                sh[i] = sda_i;
                sclk_o <= 1'b0;
            end
        end
        rx = sh[8:1];
        ack_n = sh[0];
    endtask : xfer
endmodule : sci_host_model

// ==== verification/tb.sv ====
// top testbench: drives the control port through the host model
// assumes: design files and sci_host_model are compiled first
`timescale 1ns/100ps
module tb;
    logic clk_i = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n_i = 1'b0;
    logic mode_strap = 1'b0;
    logic [1:0] straps = 2'b01;
    logic write_only = 1'b0;
    logic irq = 1'b0;
    logic sw_strap = 1'b1;
    logic sclk, host_low, sda_oe, sda_o, a0_o, a0_oe, alert_o, alert_oe;
    logic sw_mode, two_wire, four_wire, cs, reg_wr, ack_n;
    logic [7:0] wr_addr, rx;
    logic [15:0] wr_data;
    int err_total = 0;
    int cmp_count = 0;
    int wr_count = 0;
    wire logic sda = !((sda_oe && !sda_o) || host_low);
    wire logic a0_pin = a0_oe ? a0_o : straps[0];
    wire logic [7:0] dev = 8'hD8 | {5'h00, straps, 1'b0};

    always #2 clk_i = ~clk_i;
    initial begin
        #1.3;
        forever #40 link_clk = ~link_clk;
    end

    sci_control_port i_sci_control_port (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
        .software_control_strap_i(sw_strap),
        .interface_mode_strap_i(mode_strap),
        .serial_data_io_i(sda), .serial_data_io_o(sda_o),
        .serial_data_io_oe_o(sda_oe),
        .data_out_or_address_low_pin_i(a0_pin),
        .data_out_or_address_low_pin_o(a0_o),
        .data_out_or_address_low_pin_oe_o(a0_oe),
        .chip_select_or_address_high_pin_i(straps[1]),
        .write_only_i(write_only), .irq_pending_i(irq),
        .alert_o(alert_o), .alert_oe_o(alert_oe),
        .software_mode_o(sw_mode), .two_wire_mode_o(two_wire),
        .four_wire_select_o(four_wire), .chip_select_o(cs),
        .reg_wr_o(reg_wr), .reg_wr_addr_o(wr_addr),
        .reg_wr_data_o(wr_data));

    sci_host_model i_sci_host_model (.tick_i(link_clk), .sda_i(sda),
        .sclk_o(sclk), .sda_low_o(host_low));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle

    task automatic sendb(input logic [7:0] b, input logic exp_n);
        i_sci_host_model.xfer(b, 1'b1, rx, ack_n);
        chk({15'h0000, ack_n}, {15'h0000, exp_n});
    endtask : sendb

    task automatic rdw(input logic [15:0] exp, input logic last);
        logic [15:0] w;
        i_sci_host_model.xfer(8'hFF, 1'b0, rx, ack_n);
        w[15:8] = rx;
        i_sci_host_model.xfer(8'hFF, last, rx, ack_n);
        w[7:0] = rx;
        chk(w, exp);
    endtask : rdw

    task automatic rd_at(input logic [7:0] ra);
        i_sci_host_model.start();
        sendb(dev, 1'b0);
        sendb(ra, 1'b0);
        i_sci_host_model.start();
        sendb(dev | 8'h01, 1'b0);
    endtask : rd_at

    task automatic wr_at(input logic [7:0] ra, input logic [15:0] d);
        i_sci_host_model.start();
        sendb(dev, 1'b0);
        sendb(ra, 1'b0);
        sendb(d[15:8], 1'b0);
        sendb(d[7:0], 1'b0);
    endtask : wr_at

    always @(posedge clk_i) begin
        if (reg_wr === 1'b1)
            wr_count++;
        if (sda_oe === 1'b1)
            chk({15'h0000, sda_o}, 16'h0000);
        if (alert_oe === 1'b1)
            chk({15'h0000, alert_o}, 16'h0000);
    end

    initial begin
        #300000;
        err_total++;
        close_out();
    end

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge clk_i);
        i_sci_host_model.pulses(3);
        @(posedge clk_i) rst_n_i <= 1'b1;
        // link side leaves reset only after two more clock pulses
        i_sci_host_model.pulses(3);
        idle(20);
        chk({14'h0000, sw_mode, two_wire}, 16'h0003);
        @(posedge clk_i) irq <= 1'b1;
        rd_at(8'h28);
        rdw(16'h0002, 1'b1);
        i_sci_host_model.stop();
        idle(10);
        chk({15'h0000, alert_oe}, 16'h0000);
        wr_at(8'h05, 16'h1234);
        i_sci_host_model.stop();
        idle(10);
        chk({wr_addr, 8'h00}, 16'h0500);
        chk(wr_data, 16'h1234);
        wr_at(8'h10, 16'hA5A5);
        sendb(8'h5A, 1'b0);
        sendb(8'h3C, 1'b0);
        i_sci_host_model.stop();
        idle(10);
        chk({wr_addr, 8'h00}, 16'h1100);
        chk(wr_data, 16'h5A3C);
        chk(wr_count[15:0], 16'h0003);
        rd_at(8'h05);
        rdw(16'h1234, 1'b1);
        i_sci_host_model.stop();
        rd_at(8'h10);
        rdw(16'hA5A5, 1'b1);
        i_sci_host_model.stop();
        i_sci_host_model.start();
        sendb(dev | 8'h01, 1'b0);
        rdw(16'h5A3C, 1'b1);
        i_sci_host_model.stop();
        // stop in mid-word leaves no write behind
        i_sci_host_model.start();
        sendb(dev, 1'b0);
        sendb(8'h07, 1'b0);
        sendb(8'h12, 1'b0);
        i_sci_host_model.stop();
        idle(10);
        chk(wr_count[15:0], 16'h0003);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i) straps <= k[1:0];
            idle(10);
            i_sci_host_model.start();
            sendb(dev, 1'b0);
            i_sci_host_model.start();
            sendb(dev ^ 8'h02, 1'b1);
            i_sci_host_model.stop();
        end
        @(posedge clk_i) straps <= 2'b01;
        write_only <= 1'b1;
        idle(10);
        i_sci_host_model.start();
        sendb(dev | 8'h01, 1'b1);
        i_sci_host_model.start();
        sendb(dev, 1'b0);
        i_sci_host_model.stop();
        @(posedge clk_i) write_only <= 1'b0;
        wr_at(8'h28, 16'h0018);
        i_sci_host_model.stop();
        idle(10);
        chk({15'h0000, alert_oe}, 16'h0001);
        i_sci_host_model.start();
        sendb(8'h19, 1'b0);
        i_sci_host_model.xfer(8'hFF, 1'b1, rx, ack_n);
        chk({8'h00, rx}, {8'h00, dev});
        i_sci_host_model.stop();
        idle(10);
        chk({15'h0000, alert_oe}, 16'h0001);
        wr_at(8'h20, 16'h0F0F);
        sendb(8'h0F, 1'b1);
        i_sci_host_model.stop();
        @(posedge clk_i) mode_strap <= 1'b1;
        idle(10);
        chk({11'h000, two_wire, four_wire, cs, a0_oe, a0_o}, 16'h000E);
        i_sci_host_model.start();
        sendb(dev, 1'b1);
        i_sci_host_model.stop();
        @(posedge clk_i) mode_strap <= 1'b0;
        idle(10);
        wr_at(8'h28, 16'h0038);
        i_sci_host_model.stop();
        @(posedge clk_i) mode_strap <= 1'b1;
        idle(10);
        chk({15'h0000, a0_oe}, 16'h0000);
        @(posedge clk_i) sw_strap <= 1'b0;
        mode_strap <= 1'b0;
        idle(10);
        chk({12'h000, sw_mode, two_wire, four_wire, cs}, 16'h0000);
        i_sci_host_model.start();
        sendb(dev, 1'b1);
        i_sci_host_model.stop();
        close_out();
    end
endmodule : tb
